/* hdl/sequence_trigger_selector.sv */
// trigger source selector for one state of the drive sequence machine
`timescale 1ns/1ns
`default_nettype none
`include "seq_trig_defs.svh"
// How it works
// R1 - codes 1..5 follow digital inputs one to five, high fires
// R2 - codes 6..9: analog one/two below low or above high, pair one
// R3 - code 10: analog one or two below first low threshold
// R4 - code 11: analog one below low one and analog two above high one
// R5 - 12: a1 below low one or input five; 13: a2 above high one or input five
// R6 - codes 14..21 repeat 6..13 with the second threshold pair
// R7 - codes 22..25 follow timed function outputs one to four
// R8 - code 26 fires once the state change delay has fully elapsed
// R9 - codes 27..31: digital input one..five or delay elapsed
// R10 - codes 32..35: a1>h1, a1<l1, a1>h2, a2<l2, each or delay elapsed
// R11 - codes 36..38 supervision over flags, 39..41 under flags
// R12 - codes 42..47: supervision flag of 36..41 or delay elapsed
// R13 - code 48 counter above limit, code 49 counter below limit
// R14 - code 50 follows the sequence logic result
// R15 - code 51 fires when speed error is within 4% of max reference
// R16 - code 52 fires when speed error is within 1% of max reference
// R17 - codes 53..56: input five and a1 below low1, low2, above high1, high2
// R18 - codes 57..59: input four and a1 below low1, low2, above high1
// R19 - delay counts 0.1 s steps from entry into the state
// R20 - code 0 gives no trigger; both selectors zero freezes the state
// R21 - undefined codes give no trigger
module sequence_trigger_selector
  import seq_trig_pkg::*;
#(
  parameter int AW              = 16,
  parameter int RW              = 16,
  parameter int CW              = 16,
  parameter int DLY_TICK_CYCLES = `DLY_TICK_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [`SEL_W-1:0]           trigger_select,
  input  wire logic [`SEL_W-1:0]           alt_trigger_select,
  input  wire logic                        state_entry,
  input  wire logic [`DLY_W-1:0]           state_change_delay,
  input  wire logic [4:0]                  digital_inputs,
  input  wire logic signed [AW-1:0]        analog_input_one,
  input  wire logic signed [AW-1:0]        analog_input_two,
  input  wire logic signed [AW-1:0]        first_low_threshold,
  input  wire logic signed [AW-1:0]        first_high_threshold,
  input  wire logic signed [AW-1:0]        second_low_threshold,
  input  wire logic signed [AW-1:0]        second_high_threshold,
  input  wire logic [3:0]                  timed_function_output,
  input  wire logic [2:0]                  supervision_over_flag,
  input  wire logic [2:0]                  supervision_under_flag,
  input  wire logic [CW-1:0]               pulse_counter_value,
  input  wire logic [CW-1:0]               counter_limit,
  input  wire logic                        sequence_logic_result,
  input  wire logic signed [RW-1:0]        actual_speed,
  input  wire logic signed [RW-1:0]        speed_reference,
  input  wire logic [RW-1:0]               max_reference,
  output logic                             trigger,
  output logic                             state_frozen,
  output logic                             delay_elapsed
);

  //////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // refused at elaboration: a one-bit signed level cannot hold a threshold
  if (AW < 2 || RW < 2 || CW < 1) begin : g_bad_width
    $error("sequence_trigger_selector: widths too small");
  end
  if (DLY_TICK_CYCLES < 1) begin : g_bad_tick
    $error("sequence_trigger_selector: tick must be at least one cycle");
  end

  localparam int TW = (DLY_TICK_CYCLES > 1) ? $clog2(DLY_TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(DLY_TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // analog comparisons

  logic a1_lo1, a1_hi1, a2_lo1, a2_hi1;
  logic a1_lo2, a1_hi2, a2_lo2, a2_hi2;

  threshold_compare #(.AW(AW)) u_a1_p1 (
    .value      (analog_input_one),
    .low_thr    (first_low_threshold),
    .high_thr   (first_high_threshold),
    .below_low  (a1_lo1),
    .above_high (a1_hi1)
  );
  threshold_compare #(.AW(AW)) u_a2_p1 (
    .value      (analog_input_two),
    .low_thr    (first_low_threshold),
    .high_thr   (first_high_threshold),
    .below_low  (a2_lo1),
    .above_high (a2_hi1)
  );
  threshold_compare #(.AW(AW)) u_a1_p2 (
    .value      (analog_input_one),
    .low_thr    (second_low_threshold),
    .high_thr   (second_high_threshold),
    .below_low  (a1_lo2),
    .above_high (a1_hi2)
  );
  threshold_compare #(.AW(AW)) u_a2_p2 (
    .value      (analog_input_two),
    .low_thr    (second_low_threshold),
    .high_thr   (second_high_threshold),
    .below_low  (a2_lo2),
    .above_high (a2_hi2)
  );

  //////////////////////////////////////////////////////////////////////////////
  // speed versus reference windows

  logic near_reference_condition;
  logic on_reference_condition;

  reference_window #(.RW(RW)) u_ref (
    .actual_speed    (actual_speed),
    .speed_reference (speed_reference),
    .max_reference   (max_reference),
    .near_ok         (near_reference_condition),
    .on_ok           (on_reference_condition)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state change delay timer

  dly_state_t          dly_state_q, dly_state_d;
  logic [TW-1:0]       tick_q, tick_d;
  logic [`DLY_W-1:0]   dcount_q, dcount_d;

  // restarts on every state entry; a zero delay counts as elapsed at once
  always_comb begin
    dly_state_d = dly_state_q;
    tick_d      = tick_q;
    dcount_d    = dcount_q;
    if (state_entry) begin // [R19]
      tick_d      = '0;
      dcount_d    = '0;
      dly_state_d = (state_change_delay == '0) ? DLY_ELAPSED : DLY_RUN;
    end else begin
      unique case (dly_state_q)
        DLY_IDLE: begin
          dly_state_d = DLY_IDLE;
        end
        DLY_RUN: begin
          // one count per 0.1 s tick
          if (tick_q == TICK_LAST) begin // [R19]
            tick_d   = '0;
            dcount_d = dcount_q + 1'b1;
            if (dcount_q + 1'b1 >= state_change_delay)
              dly_state_d = DLY_ELAPSED;
          end else begin
            tick_d = tick_q + 1'b1;
          end
        end
        DLY_ELAPSED: begin
          dly_state_d = DLY_ELAPSED;
        end
        default: begin
          dly_state_d = DLY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dly_state_q <= DLY_IDLE;
      tick_q      <= '0;
      dcount_q    <= '0;
    end else begin
      dly_state_q <= dly_state_d;
      tick_q      <= tick_d;
      dcount_q    <= dcount_d;
    end
  end

  logic dly_done;
  assign dly_done = (dly_state_q == DLY_ELAPSED);

  //////////////////////////////////////////////////////////////////////////////
  // source selection

  logic [4:0] di;
  logic       digital_input_four, digital_input_five;
  logic [5:0] spv;
  logic       trig_d, frozen_d;

  assign di  = digital_inputs;
  assign digital_input_four = di[3];
  assign digital_input_five = di[4];
  assign spv = {supervision_under_flag, supervision_over_flag};

  // one flat decode keeps the code-to-source map easy to audit
  always_comb begin
    trig_d = 1'b0;
    unique case (trigger_select)
      7'h00: trig_d = 1'b0;                                         // [R20]
      7'h01, 7'h02, 7'h03, 7'h04, 7'h05:
        trig_d = di[3'(trigger_select - `SEL_DI_FIRST)];              // [R1]
      7'h06: trig_d = a1_lo1;                                       // [R2]
      7'h07: trig_d = a1_hi1;                                       // [R2]
      7'h08: trig_d = a2_lo1;                                       // [R2]
      7'h09: trig_d = a2_hi1;                                       // [R2]
      7'h0a: trig_d = a1_lo1 | a2_lo1;                              // [R3]
      7'h0b: trig_d = a1_lo1 & a2_hi1;                              // [R4]
      7'h0c: trig_d = a1_lo1 | digital_input_five;                  // [R5]
      7'h0d: trig_d = a2_hi1 | digital_input_five;                  // [R5]
      7'h0e: trig_d = a1_lo2;                                       // [R6]
      7'h0f: trig_d = a1_hi2;                                       // [R6]
      7'h10: trig_d = a2_lo2;                                       // [R6]
      7'h11: trig_d = a2_hi2;                                       // [R6]
      7'h12: trig_d = a1_lo2 | a2_lo2;                              // [R6]
      7'h13: trig_d = a1_lo2 & a2_hi2;                              // [R6]
      7'h14: trig_d = a1_lo2 | digital_input_five;                  // [R6]
      7'h15: trig_d = a2_hi2 | digital_input_five;                  // [R6]
      7'h16, 7'h17, 7'h18, 7'h19:
        trig_d = timed_function_output[2'(trigger_select - `SEL_TF_FIRST)]; // [R7]
      7'h1a: trig_d = dly_done;                                     // [R8]
      7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h1f:
        trig_d = di[3'(trigger_select - `SEL_DI_DLY_FIRST)] | dly_done; // [R9]
      7'h20: trig_d = a1_hi1 | dly_done;                            // [R10]
      7'h21: trig_d = a1_lo1 | dly_done;                            // [R10]
      7'h22: trig_d = a1_hi2 | dly_done;                            // [R10]
      7'h23: trig_d = a2_lo2 | dly_done;                            // [R10]
      7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29:
        trig_d = spv[3'(trigger_select - 7'h24)];                   // [R11]
      7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f:
        trig_d = spv[3'(trigger_select - 7'h2a)] | dly_done;        // [R12]
      7'h30: trig_d = pulse_counter_value > counter_limit;          // [R13]
      7'h31: trig_d = pulse_counter_value < counter_limit;          // [R13]
      7'h32: trig_d = sequence_logic_result;                        // [R14]
      7'h33: trig_d = near_reference_condition;                     // [R15]
      7'h34: trig_d = on_reference_condition;                       // [R16]
      7'h35: trig_d = digital_input_five & a1_lo1;                  // [R17]
      7'h36: trig_d = digital_input_five & a1_lo2;                  // [R17]
      7'h37: trig_d = digital_input_five & a1_hi1;                  // [R17]
      7'h38: trig_d = digital_input_five & a1_hi2;                  // [R17]
      7'h39: trig_d = digital_input_four & a1_lo1;                  // [R18]
      7'h3a: trig_d = digital_input_four & a1_lo2;                  // [R18]
      7'h3b: trig_d = digital_input_four & a1_hi1;                  // [R18]
      default: trig_d = 1'b0;                                       // [R21]
    endcase
    // no transition can ever leave the state while both selectors are off
    frozen_d = (trigger_select == `SEL_NONE) && (alt_trigger_select == `SEL_NONE); // [R20]
  end

  // registered outputs: one cycle from input to trigger
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigger       <= 1'b0;
      state_frozen  <= 1'b0;
      delay_elapsed <= 1'b0;
    end else begin
      trigger       <= trig_d;
      state_frozen  <= frozen_d;
      delay_elapsed <= dly_done;
    end
  end

endmodule // sequence_trigger_selector
`default_nettype wire

/* hdl/seq_trig_defs.svh */
// constants for the sequence trigger selector: codes, widths and timing counts
`ifndef SEQ_TRIG_DEFS_SVH
`define SEQ_TRIG_DEFS_SVH

`define SEL_W            7
`define SEL_NONE         7'h00
`define SEL_DI_FIRST     7'h01
`define SEL_DI_LAST      7'h05
`define SEL_TF_FIRST     7'h16
`define SEL_DLY_ONLY     7'h1a
`define SEL_DI_DLY_FIRST 7'h1b
`define SEL_LAST         7'h3b

`define DLY_W            16
`define DLY_TICK_NS      100000000
`define CLK_PERIOD_NS    8
`define DLY_TICK_CYCLES  (`DLY_TICK_NS / `CLK_PERIOD_NS)

`define NEAR_PCT         4
`define ON_PCT           1
`define PCT_FULL         100

`endif

/* hdl/seq_trig_pkg.sv */
// types shared by the sequence trigger selector files
package seq_trig_pkg;
  typedef enum logic [1:0] {
    DLY_IDLE    = 2'b00,
    DLY_RUN     = 2'b01,
    DLY_ELAPSED = 2'b10
  } dly_state_t;
endpackage : seq_trig_pkg

/* hdl/threshold_compare.sv */
// one analog input compared against a low and a high threshold
`timescale 1ns/1ns
`default_nettype none
module threshold_compare #(
  parameter int AW = 16
) (
  input  wire logic signed [AW-1:0] value,
  input  wire logic signed [AW-1:0] low_thr,
  input  wire logic signed [AW-1:0] high_thr,
  output logic                      below_low,
  output logic                      above_high
);
  // strict comparisons: equal to a threshold fires neither side
  assign below_low  = value < low_thr;
  assign above_high = value > high_thr;
endmodule // threshold_compare
`default_nettype wire

/* hdl/reference_window.sv */
// checks the speed error against a percentage of the maximum reference
`timescale 1ns/1ns
`default_nettype none
`include "seq_trig_defs.svh"
module reference_window #(
  parameter int RW = 16
) (
  input  wire logic signed [RW-1:0] actual_speed,
  input  wire logic signed [RW-1:0] speed_reference,
  input  wire logic        [RW-1:0] max_reference,
  output logic                      near_ok,
  output logic                      on_ok
);
  logic signed [RW+1:0] diff;
  logic        [RW+1:0] abs_diff;
  logic        [RW+8:0] err_scaled;
  logic        [RW+8:0] near_lim;
  logic        [RW+8:0] on_lim;

  // compare err*100 against max*pct, avoiding a divider
  always_comb begin
    diff       = {{2{actual_speed[RW-1]}}, actual_speed} - {{2{speed_reference[RW-1]}}, speed_reference};
    abs_diff   = diff[RW+1] ? (RW+2)'(-diff) : (RW+2)'(diff);
    err_scaled = (RW+9)'(abs_diff) * (RW+9)'(`PCT_FULL);
    near_lim   = (RW+9)'(max_reference) * (RW+9)'(`NEAR_PCT);
    on_lim     = (RW+9)'(max_reference) * (RW+9)'(`ON_PCT);
    near_ok    = err_scaled <= near_lim; // [R15]
    on_ok      = err_scaled <= on_lim;   // [R16]
  end
endmodule // reference_window
`default_nettype wire

/* testbench/seq_trig_checker_asserts.sv */
// concurrent checks on the trigger selector ports
`timescale 1ns/1ns
`default_nettype none
`include "seq_trig_defs.svh"
module seq_trig_checker #(
  parameter int CW              = 16,
  parameter int DLY_TICK_CYCLES = 4
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [`SEL_W-1:0] trigger_select,
  input wire logic [`SEL_W-1:0] alt_trigger_select,
  input wire logic              state_entry,
  input wire logic [`DLY_W-1:0] state_change_delay,
  input wire logic [4:0]        digital_inputs,
  input wire logic [3:0]        timed_function_output,
  input wire logic [CW-1:0]     pulse_counter_value,
  input wire logic [CW-1:0]     counter_limit,
  input wire logic              trigger,
  input wire logic              state_frozen,
  input wire logic              delay_elapsed
);
  // entry edge to first sampled high of the elapsed flag for a one-count delay
  localparam int LAT = DLY_TICK_CYCLES + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // one edge of latency; $past(rst_n) skips the edge that leaves reset
  a_code_zero: assert property (
    $past(rst_n) && $past(trigger_select) == 7'h00 |-> !trigger)
    else $error("trigger fired on code zero");
  a_code_undef: assert property (
    $past(rst_n) && $past(trigger_select) > 7'h3b |-> !trigger)
    else $error("trigger fired on undefined code");
  a_input_follow: assert property (
    $past(rst_n) && $past(trigger_select) inside {[7'h01:7'h05]}
    |-> trigger == $past(digital_inputs[trigger_select - 7'h01]))
    else $error("trigger does not follow digital input");
  a_timed_follow: assert property (
    $past(rst_n) && $past(trigger_select) inside {[7'h16:7'h19]}
    |-> trigger == $past(timed_function_output[trigger_select - 7'h16]))
    else $error("trigger does not follow timed function");
  a_delay_only: assert property (
    $past(rst_n) && $past(trigger_select) == 7'h1a |-> trigger == delay_elapsed)
    else $error("delay code trigger differs from elapsed flag");
  a_input_or_delay: assert property (
    $past(rst_n) && $past(trigger_select) inside {[7'h1b:7'h1f]}
    |-> trigger == ($past(digital_inputs[trigger_select - 7'h1b]) || delay_elapsed))
    else $error("input or delay trigger wrong");
  a_counter_over: assert property (
    $past(rst_n) && $past(trigger_select) == 7'h30
    |-> trigger == $past(pulse_counter_value > counter_limit))
    else $error("counter over trigger wrong");
  a_freeze_flag: assert property (
    $past(rst_n) |-> state_frozen ==
    ($past(trigger_select) == 7'h00 && $past(alt_trigger_select) == 7'h00))
    else $error("freeze flag wrong");
  a_delay_time: assert property (
    $rose(delay_elapsed) && state_change_delay == 16'h0001 |-> $past(state_entry, LAT))
    else $error("one-count delay elapsed at wrong time");
  // main scenarios reached
  c_delay_fire: cover property (trigger_select == 7'h1a && trigger);
  c_elapse: cover property ($rose(delay_elapsed));
  c_frozen: cover property (state_frozen);
endmodule // seq_trig_checker
bind sequence_trigger_selector seq_trig_checker #(
  .CW(CW), .DLY_TICK_CYCLES(DLY_TICK_CYCLES)) seq_trig_checker_i (
  .clk, .rst_n, .trigger_select, .alt_trigger_select, .state_entry,
  .state_change_delay, .digital_inputs, .timed_function_output,
  .pulse_counter_value, .counter_limit, .trigger, .state_frozen, .delay_elapsed);
`default_nettype wire

/* testbench/seq_machine_model.sv */
// sequence machine model: enters a state on start or on a fresh trigger
`timescale 1ns/1ns
`default_nettype none
module seq_machine_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  input  wire logic state_frozen,
  input  wire logic start,
  input  wire logic follow,
  output logic      state_entry,
  output int        moves
);
  logic trig_q;
  // one move per rising trigger, so a held trigger cannot re-enter forever
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_entry <= 1'b0;
      trig_q      <= 1'b0;
      moves       <= 0;
    end else begin
      trig_q      <= trigger;
      state_entry <= start | (follow & trigger & !trig_q & !state_frozen);
      if (follow && trigger && !trig_q && !state_frozen) moves <= moves + 1;
    end
  end
endmodule // seq_machine_model
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the sequence trigger selector
`timescale 1ns/1ns
`default_nettype none
`include "seq_trig_defs.svh"
module testbench;
  localparam int TICK = 4;
  localparam logic signed [15:0] a1_set [3] = '{-16'sh96, 16'shfa, -16'sh64};
  localparam logic signed [15:0] a2_set [3] = '{16'sh96, -16'shfa, 16'shc8};
  localparam logic signed [15:0] act_set [3] = '{16'sh410, 16'sh3de, 16'sh411};
  localparam logic [15:0] cnt_set [3] = '{16'h000a, 16'h000b, 16'h0009};
  localparam logic [4:0] di_set [3] = '{5'h15, 5'h0a, 5'h00};
  localparam logic [3:0] tf_set [3] = '{4'h5, 4'ha, 4'h0};
  localparam logic [2:0] so_set [3] = '{3'h5, 3'h2, 3'h0};
  localparam logic [2:0] su_set [3] = '{3'h2, 3'h5, 3'h0};
  logic               clk = 1'b0, rst_n = 1'b0, start = 1'b0, follow = 1'b0, lg = 1'b0;
  logic [6:0]         sel = 7'h00, alt = 7'h05;
  logic [15:0]        dly = 16'h0001, cnt = 16'h0000, lim = 16'h0000, mx = 16'h0000;
  logic signed [15:0] a1 = 16'sh0, a2 = 16'sh0, act = 16'sh0, rf = 16'sh0;
  logic signed [15:0] l1 = 16'sh0, h1 = 16'sh0, l2 = 16'sh0, h2 = 16'sh0;
  logic [4:0]         di = 5'h00;
  logic [3:0]         tf = 4'h0;
  logic [2:0]         so = 3'h0, su = 3'h0;
  logic               trig, frz, de_o, entry, de = 1'b0;
  int                 bad_count = 0, num_checks = 0, cyc = 0, moves, n;
  ////////////////////////////////////////////////////////////
  sequence_trigger_selector #(.DLY_TICK_CYCLES(TICK)) sequence_trigger_selector_i (
    .clk, .rst_n, .trigger_select(sel), .alt_trigger_select(alt), .state_entry(entry),
    .state_change_delay(dly), .digital_inputs(di), .analog_input_one(a1),
    .analog_input_two(a2), .first_low_threshold(l1), .first_high_threshold(h1),
    .second_low_threshold(l2), .second_high_threshold(h2), .timed_function_output(tf),
    .supervision_over_flag(so), .supervision_under_flag(su), .pulse_counter_value(cnt),
    .counter_limit(lim), .sequence_logic_result(lg), .actual_speed(act),
    .speed_reference(rf), .max_reference(mx), .trigger(trig), .state_frozen(frz),
    .delay_elapsed(de_o));
  seq_machine_model seq_machine_model_i (.clk, .rst_n, .trigger(trig),
    .state_frozen(frz), .start, .follow, .state_entry(entry), .moves);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // one analog group; codes 14..21 reuse it with the second pair
  function automatic logic grp(logic signed [15:0] lo, hi, int k);
    case (k)
      0: return a1 < lo;
      1: return a1 > hi;
      2: return a2 < lo;
      3: return a2 > hi;
      4: return a1 < lo || a2 < lo;
      5: return a1 < lo && a2 > hi;
      6: return a1 < lo || di[4];
      default: return a2 > hi || di[4];
    endcase
  endfunction
  // expected trigger for a code from what the bench drives
  function automatic logic fire(int c);
    int d;
    d = (act > rf) ? act - rf : rf - act;
    case (c) inside
      [1:5]: return di[c-1];
      [6:13]: return grp(l1, h1, c - 6);
      [14:21]: return grp(l2, h2, c - 14);
      [22:25]: return tf[c-22];
      26: return de;
      [27:31]: return di[c-27] | de;
      32: return a1 > h1 | de;
      33: return a1 < l1 | de;
      34: return a1 > h2 | de;
      35: return a2 < l2 | de;
      [36:38]: return so[c-36];
      [39:41]: return su[c-39];
      [42:44]: return so[c-42] | de;
      [45:47]: return su[c-45] | de;
      48: return cnt > lim;
      49: return cnt < lim;
      50: return lg;
      51: return d * `PCT_FULL <= mx * `NEAR_PCT;
      52: return d * `PCT_FULL <= mx * `ON_PCT;
      // odd codes use pair one, even codes pair two; 53,54 low side, 55,56 high side
      [53:56]: return di[4] & grp(c[0] ? l1 : l2, c[0] ? h1 : h2, c[1] ^ c[0] ? 0 : 1);
      57: return di[3] & a1 < l1;
      58: return di[3] & a1 < l2;
      59: return di[3] & a1 > h1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // thresholds scale with k, so every level moves yet comparisons keep their sense
  task automatic setup(int k);
    @(posedge clk);
    a1  <= a1_set[k] <<< k;
    a2  <= a2_set[k] <<< k;
    l1  <= -16'sh64 <<< k;
    h1  <= 16'sh64 <<< k;
    l2  <= -16'shc8 <<< k;
    h2  <= 16'shc8 <<< k;
    act <= act_set[k] <<< k;
    rf  <= 16'sh3e8 <<< k;
    mx  <= 16'h03e8 << k;
    cnt <= cnt_set[k] << k;
    lim <= 16'h000a << k;
    di  <= di_set[k];
    tf  <= tf_set[k];
    so  <= so_set[k];
    su  <= su_set[k];
    lg  <= k[0];
    alt <= (k == 1) ? 7'h00 : 7'h05;
    for (int c = 0; c < 128; c++) begin
      @(posedge clk) sel <= 7'(c);
      @(posedge clk);
      @(negedge clk);
      check(trig, fire(c));
      check(frz, c == 0 && alt == 7'h00);
    end
  endtask
  // restart the state and count edges until the delay reports elapsed
  task automatic time_delay(logic [15:0] d);
    @(posedge clk);
    sel   <= 7'h1a;
    dly   <= d;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk iff entry);
    // n counts rising edges after the entry edge, looked at mid-cycle
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (!de_o && n < 200);
    check(n, 1 + d * TICK);
    check(trig, 1'b1);
  endtask
  // cut a hang short; the whole run needs about 800 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    setup(0);
    setup(1);
    time_delay(16'h0001);
    time_delay(16'h0003);
    de = 1'b1;
    setup(2);
    // a fresh trigger makes the machine re-enter, which restarts the delay
    @(posedge clk);
    sel    <= 7'h01;
    follow <= 1'b1;
    @(posedge clk) di <= 5'h01;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(moves, 1);
    check(de_o, 1'b0);
    test_done();
  end
endmodule // testbench
`default_nettype wire
